// ==== logic/glc_global_ctrl.sv ====
`timescale 1ns/1ns
// What this block does
// - timeout interrupt asserts, released on flag read
// - disabled ports stop PWM; sinks, inputs left to port bank via port_func_en_o
// - disabled plus key sleep powers everything down
// - enabled ports run regardless of key sleep
// - soft reset restores port registers, self clears
// - fade code zero means no fading
// - fade codes select 256 to 4096 ms
// - debounce time is 9 ms plus code
// - current select: 0 gives 20 mA, 1 gives 10 mA
// - common duty N/256, code 255 full on
// - flag shows timeout since last read
// - reading flag register clears the flag
// - flag set only with timeout detection enabled
// - common select uses shared PWM duty
module glc_global_ctrl #(
   parameter int unsigned MS_CYCLES = glc_pkg::MS_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire glc_pkg::glc_reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic port_wr_o,
   output logic port_soft_rst_o,
   input wire logic bus_timeout_i,
   input wire logic timeout_det_en_i,
   input wire logic key_sleep_i,
   input wire logic fade_up_i,
   input wire logic [glc_pkg::LED_PORTS-1:0] port_common_sel_i,
   input wire logic [glc_pkg::LED_PORTS-1:0][7:0] port_own_duty_i,
   output logic int_n_o,
   output logic port_func_en_o,
   output logic power_down_o,
   output logic led_10ma_o,
   output logic [5:0] debounce_ms_o,
   output logic [7:0] shared_duty_o,
   output logic [glc_pkg::LED_PORTS-1:0] led_pwm_o
);
   glc_pkg::glc_global_t gcfg, next_gcfg;
   logic [4:0] deb, next_deb;
   logic [5:0] deb_ms, next_deb_ms;
   logic cur10, next_cur10;
   logic [7:0] spwm, next_spwm;
   logic to_flag, next_to_flag;
   logic [7:0] rdata, next_rdata;
   logic soft_rst, next_soft_rst;
   logic pdown, next_pdown;
   logic [7:0] pwm_cnt, next_pwm_cnt;
   logic [glc_pkg::LED_PORTS-1:0] pwm_q, next_pwm_q;
   logic [glc_pkg::LED_PORTS-1:0] port_on;
   logic [7:0] shared_duty, next_shared_duty;
   logic [4:0] fade_level;
   logic [12:0] fade_prod;
   logic [7:0] rd_byte;
   logic wr_open;

   function automatic logic in_port_range(input logic [7:0] a);
      return (a >= glc_pkg::ADDR_PORT_FIRST) && (a <= glc_pkg::ADDR_PORT_LAST);
   endfunction : in_port_range

   // code 255 is the one value that may not leave a gap in the period
   function automatic logic duty_on(input logic [7:0] duty, input logic [7:0] cnt);
      return (duty == glc_pkg::PWM_FULL) || (cnt < duty);
   endfunction : duty_on

   // the global register itself stays writable, else the lock could never be lifted
   assign wr_open = reg_req_i.wr &&
      (reg_req_i.addr == glc_pkg::ADDR_GLOBAL || !in_port_range(reg_req_i.addr) ||
       gcfg.port_en);
   assign port_wr_o = reg_req_i.wr && in_port_range(reg_req_i.addr) && gcfg.port_en;

   glc_fade_engine #(
      .MS_CYCLES(MS_CYCLES)
   ) u_fade (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(gcfg.port_en),
      .fade_up_i(fade_up_i),
      .fade_code_i(gcfg.fade),
      .level_o(fade_level)
   );

   assign fade_prod = {5'h00, spwm} * {8'h00, fade_level};

   always_comb begin
      rd_byte = 8'h00;
      case (reg_req_i.addr)
         glc_pkg::ADDR_GLOBAL: begin
            rd_byte[glc_pkg::GC_TO_INT_EN_BIT] = gcfg.to_int_en;
            rd_byte[glc_pkg::GC_PORT_EN_BIT] = gcfg.port_en;
            rd_byte[glc_pkg::GC_FADE_MSB:glc_pkg::GC_FADE_LSB] = gcfg.fade;
         end
         glc_pkg::ADDR_DEBOUNCE: rd_byte[glc_pkg::DEB_MSB:0] = deb;
         glc_pkg::ADDR_LED_CUR: begin
            rd_byte[glc_pkg::CUR_FIXED_MSB:glc_pkg::CUR_FIXED_LSB] = glc_pkg::CUR_FIXED;
            rd_byte[glc_pkg::CUR_SEL_BIT] = cur10;
         end
         glc_pkg::ADDR_SHARED_PWM: rd_byte = spwm;
         glc_pkg::ADDR_TO_FLAG: rd_byte[glc_pkg::TO_FLAG_BIT] = to_flag;
         default: rd_byte = 8'h00;
      endcase
   end

   always_comb begin
      next_gcfg = gcfg;
      next_deb = deb;
      next_cur10 = cur10;
      next_spwm = spwm;
      next_soft_rst = 1'b0;
      if (wr_open && reg_req_i.addr == glc_pkg::ADDR_GLOBAL) begin
         if (reg_req_i.wdata[glc_pkg::GC_SOFT_RST_BIT]) begin
            next_gcfg = glc_pkg::GC_RST;
            next_deb = glc_pkg::DEB_RST;
            next_cur10 = glc_pkg::CUR_RST;
            next_spwm = glc_pkg::PWM_RST;
            next_soft_rst = 1'b1;
         end else begin
            next_gcfg.to_int_en = reg_req_i.wdata[glc_pkg::GC_TO_INT_EN_BIT];
            next_gcfg.port_en = reg_req_i.wdata[glc_pkg::GC_PORT_EN_BIT];
            next_gcfg.fade = reg_req_i.wdata[glc_pkg::GC_FADE_MSB:glc_pkg::GC_FADE_LSB];
         end
      end
      if (wr_open && reg_req_i.addr == glc_pkg::ADDR_DEBOUNCE) begin
         next_deb = reg_req_i.wdata[glc_pkg::DEB_MSB:0];
      end
      if (wr_open && reg_req_i.addr == glc_pkg::ADDR_LED_CUR) begin
         next_cur10 = reg_req_i.wdata[glc_pkg::CUR_SEL_BIT];
      end
      if (wr_open && reg_req_i.addr == glc_pkg::ADDR_SHARED_PWM) begin
         next_spwm = reg_req_i.wdata;
      end
      next_deb_ms = glc_pkg::DEB_BASE_MS + {1'b0, next_deb};
   end

   // a timeout landing on the clearing read is kept, so no event is lost
   always_comb begin
      next_to_flag = to_flag;
      if (reg_req_i.rd && reg_req_i.addr == glc_pkg::ADDR_TO_FLAG) begin
         next_to_flag = 1'b0;
      end
      if (bus_timeout_i && timeout_det_en_i) begin
         next_to_flag = 1'b1;
      end
      next_rdata = reg_req_i.rd ? rd_byte : rdata;
      next_pdown = !gcfg.port_en && key_sleep_i;
   end

   generate
      for (genvar i = 0; i < glc_pkg::LED_PORTS; i++) begin : g_port
         assign port_on[i] = duty_on(port_common_sel_i[i] ? shared_duty :
            port_own_duty_i[i], pwm_cnt);
      end
   endgenerate

   always_comb begin
      next_pwm_cnt = pwm_cnt + 8'h01;
      next_pwm_q = gcfg.port_en ? port_on : '0;
      next_shared_duty = fade_prod[glc_pkg::LVL_SHIFT +: 8];
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gcfg <= glc_pkg::GC_RST;
         deb <= glc_pkg::DEB_RST;
         deb_ms <= glc_pkg::DEB_BASE_MS;
         cur10 <= glc_pkg::CUR_RST;
         spwm <= glc_pkg::PWM_RST;
         to_flag <= 1'b0;
         rdata <= 8'h00;
         soft_rst <= 1'b0;
         pdown <= 1'b0;
         pwm_cnt <= 8'h00;
         pwm_q <= '0;
         shared_duty <= glc_pkg::PWM_RST;
      end else begin
         gcfg <= next_gcfg;
         deb <= next_deb;
         deb_ms <= next_deb_ms;
         cur10 <= next_cur10;
         spwm <= next_spwm;
         to_flag <= next_to_flag;
         rdata <= next_rdata;
         soft_rst <= next_soft_rst;
         pdown <= next_pdown;
         pwm_cnt <= next_pwm_cnt;
         pwm_q <= next_pwm_q;
         shared_duty <= next_shared_duty;
      end
   end

   // port outputs (level holding) and inputs are left to the port bank via port_func_en_o, only PWM stops here
   assign port_func_en_o = gcfg.port_en;
   assign int_n_o = !(to_flag && gcfg.to_int_en);
   assign reg_rdata_o = rdata;
   assign port_soft_rst_o = soft_rst;
   assign power_down_o = pdown;
   assign led_10ma_o = cur10;
   assign debounce_ms_o = deb_ms;
   assign shared_duty_o = shared_duty;
   assign led_pwm_o = pwm_q;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_gc_wr;
      reg_req_i.wr && reg_req_i.addr == glc_pkg::ADDR_GLOBAL;
   endsequence
   sequence s_flag_rd;
      reg_req_i.rd && reg_req_i.addr == glc_pkg::ADDR_TO_FLAG;
   endsequence
   sequence s_soft_wr;
      s_gc_wr and reg_req_i.wdata[glc_pkg::GC_SOFT_RST_BIT];
   endsequence
   sequence s_defaults;
      port_soft_rst_o && !gcfg.port_en && spwm == glc_pkg::PWM_RST && deb == glc_pkg::DEB_RST;
   endsequence

   property p_int_set;
      (bus_timeout_i && timeout_det_en_i && gcfg.to_int_en && !reg_req_i.wr) |=> !int_n_o;
   endproperty
   a_int_set: assert property (p_int_set) else $error("timeout did not raise interrupt");

   property p_int_release;
      (s_flag_rd and !bus_timeout_i && !reg_req_i.wr) |=> int_n_o && !to_flag;
   endproperty
   a_int_release: assert property (p_int_release) else $error("flag read left interrupt");

   property p_flag_cause;
      $rose(to_flag) |-> $past(bus_timeout_i && timeout_det_en_i);
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("flag set without timeout");

   property p_flag_read;
      (s_flag_rd and to_flag) |=> reg_rdata_o[glc_pkg::TO_FLAG_BIT];
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag read returned zero");

   property p_lock;
      (reg_req_i.wr && reg_req_i.addr == glc_pkg::ADDR_DEBOUNCE && !gcfg.port_en) |=>
         $stable(deb) && !$past(port_wr_o);
   endproperty
   a_lock: assert property (p_lock) else $error("locked register changed");

   property p_soft_reset;
      s_soft_wr |=> s_defaults ##1 (!port_soft_rst_o || $past(reg_req_i.wr));
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset misbehaved");

   property p_power_down;
      (!gcfg.port_en && key_sleep_i) |=> power_down_o;
   endproperty
   a_power_down: assert property (p_power_down) else $error("no full power down");

   property p_awake;
      gcfg.port_en [*2] |-> !power_down_o && port_func_en_o;
   endproperty
   a_awake: assert property (p_awake) else $error("enabled ports powered down");

   property p_pwm_off;
      !gcfg.port_en |=> led_pwm_o == '0;
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("pwm runs while disabled");

   property p_full_duty;
      (gcfg.port_en && port_common_sel_i[0] && shared_duty == glc_pkg::PWM_FULL) |=> led_pwm_o[0];
   endproperty
   a_full_duty: assert property (p_full_duty) else $error("code 255 not fully on");

   property p_own_duty;
      (gcfg.port_en && !port_common_sel_i[1] && port_own_duty_i[1] != glc_pkg::PWM_FULL &&
         pwm_cnt >= port_own_duty_i[1]) |=> !led_pwm_o[1];
   endproperty
   a_own_duty: assert property (p_own_duty) else $error("unselected port used shared duty");

   property p_debounce;
      (reg_req_i.wr && reg_req_i.addr == glc_pkg::ADDR_DEBOUNCE && gcfg.port_en) |=>
         debounce_ms_o == glc_pkg::DEB_BASE_MS + {1'b0, $past(reg_req_i.wdata[glc_pkg::DEB_MSB:0])};
   endproperty
   a_debounce: assert property (p_debounce) else $error("debounce time wrong");

   property p_current;
      (reg_req_i.wr && reg_req_i.addr == glc_pkg::ADDR_LED_CUR && gcfg.port_en) |=>
         led_10ma_o == $past(reg_req_i.wdata[glc_pkg::CUR_SEL_BIT]);
   endproperty
   a_current: assert property (p_current) else $error("current select not taken");

   property p_flag_hold;
      (to_flag && !(reg_req_i.rd && reg_req_i.addr == glc_pkg::ADDR_TO_FLAG)) |=> to_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost before read");

   property p_int_mask;
      !gcfg.to_int_en |-> int_n_o;
   endproperty
   a_int_mask: assert property (p_int_mask) else $error("interrupt raised while disabled");

   property p_port_wr_lock;
      (reg_req_i.wr && !gcfg.port_en) |-> !port_wr_o;
   endproperty
   a_port_wr_lock: assert property (p_port_wr_lock) else $error("locked port write passed");
endmodule : glc_global_ctrl

// ==== logic/glc_pkg.sv ====
package glc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned MS_CYCLES = NS_PER_MS / CLK_PERIOD_NS;

   localparam logic [7:0] ADDR_GLOBAL = 8'h40;
   localparam logic [7:0] ADDR_DEBOUNCE = 8'h42;
   localparam logic [7:0] ADDR_LED_CUR = 8'h43;
   localparam logic [7:0] ADDR_SHARED_PWM = 8'h45;
   localparam logic [7:0] ADDR_TO_FLAG = 8'h48;
   localparam logic [7:0] ADDR_PORT_FIRST = 8'h31;
   localparam logic [7:0] ADDR_PORT_LAST = 8'h5B;

   localparam int unsigned GC_TO_INT_EN_BIT = 5;
   localparam int unsigned GC_PORT_EN_BIT = 4;
   localparam int unsigned GC_SOFT_RST_BIT = 3;
   localparam int unsigned GC_FADE_MSB = 2;
   localparam int unsigned GC_FADE_LSB = 0;
   localparam int unsigned DEB_MSB = 4;
   localparam int unsigned CUR_SEL_BIT = 0;
   localparam int unsigned CUR_FIXED_MSB = 7;
   localparam int unsigned CUR_FIXED_LSB = 6;
   localparam int unsigned TO_FLAG_BIT = 0;

   localparam logic [1:0] CUR_FIXED = 2'h3;
   localparam logic [4:0] DEB_RST = 5'h00;
   localparam logic [5:0] DEB_BASE_MS = 6'h09;
   localparam logic CUR_RST = 1'b0;
   localparam logic [7:0] PWM_RST = 8'h00;
   localparam logic [7:0] PWM_FULL = 8'hFF;

   localparam logic [2:0] FADE_NONE = 3'h0;
   localparam logic [2:0] FADE_MAX_CODE = 3'h5;
   localparam int unsigned FADE_SHORTEST_MS = 256;
   localparam int unsigned FADE_STEPS = 16;
   localparam int unsigned FADE_STEP_BASE_MS = FADE_SHORTEST_MS / FADE_STEPS;
   localparam logic [4:0] LVL_MIN = 5'h00;
   localparam logic [4:0] LVL_MAX = 5'h10;
   localparam int unsigned LVL_SHIFT = 4;

   localparam int unsigned LED_PORTS = 4;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } glc_reg_req_t;

   typedef struct packed {
      logic to_int_en;
      logic port_en;
      logic [2:0] fade;
   } glc_global_t;

   localparam glc_global_t GC_RST = '{to_int_en: 1'b0, port_en: 1'b0, fade: 3'h0};

   typedef enum logic [1:0] {
      FADE_OFF = 2'h0,
      FADE_RISE = 2'h1,
      FADE_ON = 2'h3,
      FADE_FALL = 2'h2
   } glc_fade_state_t;
endpackage : glc_pkg

// ==== logic/glc_fade_engine.sv ====
`timescale 1ns/1ns
module glc_fade_engine #(
   parameter int unsigned MS_CYCLES = glc_pkg::MS_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic fade_up_i,
   input wire logic [2:0] fade_code_i,
   output logic [4:0] level_o
);
   glc_pkg::glc_fade_state_t state, next_state;
   logic [31:0] timer, next_timer;
   logic [4:0] level, next_level;
   logic [31:0] step_len;
   logic at_end;

   // undefined codes are clamped to the longest ramp so the engine never stalls
   function automatic logic [31:0] step_cycles(input logic [2:0] code);
      logic [2:0] c;
      c = (code > glc_pkg::FADE_MAX_CODE) ? glc_pkg::FADE_MAX_CODE : code;
      return 32'(MS_CYCLES * glc_pkg::FADE_STEP_BASE_MS) << (c - 3'h1);
   endfunction : step_cycles

   assign step_len = step_cycles(fade_code_i);
   assign at_end = fade_up_i ? (level == glc_pkg::LVL_MAX) : (level == glc_pkg::LVL_MIN);
   assign level_o = level;

   always_comb begin
      next_state = state;
      next_timer = timer;
      next_level = level;
      if (!enable_i) begin
         next_state = glc_pkg::FADE_OFF;
         next_timer = '0;
         next_level = glc_pkg::LVL_MIN;
      end else if (fade_code_i == glc_pkg::FADE_NONE) begin
         next_timer = '0;
         next_state = fade_up_i ? glc_pkg::FADE_ON : glc_pkg::FADE_OFF;
         next_level = fade_up_i ? glc_pkg::LVL_MAX : glc_pkg::LVL_MIN;
      end else begin
         case (state)
            glc_pkg::FADE_OFF: begin
               if (fade_up_i) next_state = glc_pkg::FADE_RISE;
            end
            glc_pkg::FADE_ON: begin
               if (!fade_up_i) next_state = glc_pkg::FADE_FALL;
            end
            glc_pkg::FADE_RISE, glc_pkg::FADE_FALL: begin
               if (at_end) begin
                  next_state = fade_up_i ? glc_pkg::FADE_ON : glc_pkg::FADE_OFF;
                  next_timer = '0;
               end else begin
                  next_state = fade_up_i ? glc_pkg::FADE_RISE : glc_pkg::FADE_FALL;
                  next_timer = timer + 32'h1;
                  if (timer >= step_len - 32'h1) begin
                     next_timer = '0;
                     next_level = fade_up_i ? level + 5'h01 : level - 5'h01;
                  end
               end
            end
            default: next_state = glc_pkg::FADE_OFF;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= glc_pkg::FADE_OFF;
         timer <= '0;
         level <= glc_pkg::LVL_MIN;
      end else begin
         state <= next_state;
         timer <= next_timer;
         level <= next_level;
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_fade_none;
      (enable_i && fade_up_i && fade_code_i == glc_pkg::FADE_NONE) |=> level_o == glc_pkg::LVL_MAX;
   endproperty
   a_fade_none: assert property (p_fade_none) else $error("no-fade code did not jump");

   property p_fade_step;
      ($past(enable_i) && $past(fade_code_i) != glc_pkg::FADE_NONE) |->
         (level_o == $past(level_o)) || (level_o == $past(level_o) + 5'h01) ||
         (level_o == $past(level_o) - 5'h01);
   endproperty
   a_fade_step: assert property (p_fade_step) else $error("fade jumped more than a step");
endmodule : glc_fade_engine

// ==== bench/glc_host_model.sv ====
`timescale 1ns/1ns
module glc_host_model (
   input wire logic sys_clk_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic port_wr_i,
   output glc_pkg::glc_reg_req_t reg_req_o
);
   logic last_port_wr;

   initial begin
      reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
      last_port_wr = 1'b0;
   end

   // an idle bus shows flipped bits so a stale address is never mistaken for a live one
   task automatic release_bus();
      reg_req_o.wr = 1'b0;
      reg_req_o.rd = 1'b0;
      reg_req_o.addr = ~reg_req_o.addr;
      reg_req_o.wdata = ~reg_req_o.wdata;
   endtask : release_bus

   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      if (addr == glc_pkg::ADDR_GLOBAL && data[2:0] > glc_pkg::FADE_MAX_CODE) begin
         return;
      end
      @(posedge sys_clk_i);
      #1;
      reg_req_o.wr = 1'b1;
      reg_req_o.addr = addr;
      reg_req_o.wdata = data;
      #1;
      last_port_wr = port_wr_i;
      @(posedge sys_clk_i);
      #1;
      release_bus();
   endtask : write

   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge sys_clk_i);
      #1;
      reg_req_o.rd = 1'b1;
      reg_req_o.addr = addr;
      @(posedge sys_clk_i);
      #1;
      data = reg_rdata_i;
      release_bus();
   endtask : read
endmodule : glc_host_model

// ==== bench/gpio_led_global_control_bench.sv ====
`timescale 1ns/1ns
module gpio_led_global_control_bench;
   logic sys_clk_i;
   logic rst_n_i;
   glc_pkg::glc_reg_req_t reg_req;
   logic [7:0] rdata;
   logic port_wr, soft_rst, int_n, func_en, pwr_dn, led_10ma;
   logic [5:0] deb_ms;
   logic [7:0] shared_duty;
   logic [3:0] led_pwm;
   logic bus_timeout_i, timeout_det_en_i, key_sleep_i, fade_up_i;
   logic [3:0] sel;
   logic [3:0][7:0] own;
   int error_cnt, checked, cycles;

   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   glc_global_ctrl #(.MS_CYCLES(4)) u_glc_global_ctrl (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req), .reg_rdata_o(rdata),
      .port_wr_o(port_wr), .port_soft_rst_o(soft_rst), .bus_timeout_i(bus_timeout_i),
      .timeout_det_en_i(timeout_det_en_i), .key_sleep_i(key_sleep_i), .fade_up_i(fade_up_i),
      .port_common_sel_i(sel), .port_own_duty_i(own), .int_n_o(int_n),
      .port_func_en_o(func_en), .power_down_o(pwr_dn), .led_10ma_o(led_10ma),
      .debounce_ms_o(deb_ms), .shared_duty_o(shared_duty), .led_pwm_o(led_pwm));

   glc_host_model u_glc_host_model (
      .sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .port_wr_i(port_wr), .reg_req_o(reg_req));

   task automatic test_done();
      if (error_cnt == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_val

   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      u_glc_host_model.read(addr, d);
      cmp_val({1'b0, d}, {1'b0, exp});
   endtask : rd_chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : wait_cyc

   // count high cycles over one full 256-cycle period, phase does not matter
   task automatic duty_chk(input int idx, input logic [8:0] exp);
      logic [8:0] n;
      n = 9'h000;
      repeat (256) begin
         @(posedge sys_clk_i);
         #1;
         n = n + {8'h00, led_pwm[idx]};
      end
      cmp_val(n, exp);
   endtask : duty_chk

   task automatic pulse_timeout();
      @(posedge sys_clk_i);
      #1;
      bus_timeout_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      bus_timeout_i = 1'b0;
   endtask : pulse_timeout

   task automatic t_reset_values();
      cmp_val({3'h0, deb_ms}, 9'h009);
      cmp_bit(led_10ma, 1'b0);
      cmp_bit(int_n, 1'b1);
      rd_chk(8'h40, 8'h00);
      rd_chk(8'h42, 8'h00);
      rd_chk(8'h43, 8'hC0);
      rd_chk(8'h45, 8'h00);
      rd_chk(8'h48, 8'h00);
      rd_chk(8'h41, 8'h00);
   endtask : t_reset_values

   task automatic t_lock_sleep();
      u_glc_host_model.write(8'h42, 8'h1F);
      rd_chk(8'h42, 8'h00);
      u_glc_host_model.write(8'h35, 8'hA5);
      cmp_bit(u_glc_host_model.last_port_wr, 1'b0);
      key_sleep_i = 1'b1;
      wait_cyc(3);
      cmp_bit(pwr_dn, 1'b1);
      cmp_bit(func_en, 1'b0);
   endtask : t_lock_sleep

   task automatic t_enable();
      u_glc_host_model.write(8'h40, 8'h10);
      wait_cyc(2);
      cmp_bit(func_en, 1'b1);
      cmp_bit(pwr_dn, 1'b0);
      u_glc_host_model.write(8'h42, 8'h1F);
      wait_cyc(1);
      cmp_val({3'h0, deb_ms}, 9'h028);
      rd_chk(8'h42, 8'h1F);
      u_glc_host_model.write(8'h43, 8'h01);
      wait_cyc(1);
      cmp_bit(led_10ma, 1'b1);
      rd_chk(8'h43, 8'hC1);
      u_glc_host_model.write(8'h35, 8'h5A);
      cmp_bit(u_glc_host_model.last_port_wr, 1'b1);
      u_glc_host_model.write(8'h48, 8'h01);
      rd_chk(8'h48, 8'h00);
   endtask : t_enable

   task automatic t_pwm();
      u_glc_host_model.write(8'h45, 8'h80);
      wait_cyc(2);
      cmp_val({1'b0, shared_duty}, 9'h080);
      duty_chk(0, 9'h080);
      duty_chk(1, 9'h040);
      u_glc_host_model.write(8'h45, 8'hFF);
      wait_cyc(2);
      duty_chk(0, 9'h100);
      u_glc_host_model.write(8'h45, 8'h00);
      wait_cyc(2);
      duty_chk(0, 9'h000);
   endtask : t_pwm

   task automatic t_fade();
      u_glc_host_model.write(8'h45, 8'h80);
      u_glc_host_model.write(8'h40, 8'h11);
      fade_up_i = 1'b0;
      wait_cyc(500);
      cmp_bit(shared_duty !== 8'h00 && shared_duty !== 8'h80, 1'b1);
      wait_cyc(600);
      cmp_val({1'b0, shared_duty}, 9'h000);
      u_glc_host_model.write(8'h40, 8'h12);
      fade_up_i = 1'b1;
      wait_cyc(1100);
      cmp_bit(shared_duty !== 8'h80, 1'b1);
      wait_cyc(1100);
      cmp_val({1'b0, shared_duty}, 9'h080);
      u_glc_host_model.write(8'h40, 8'h10);
   endtask : t_fade

   task automatic t_timeout();
      pulse_timeout();
      rd_chk(8'h48, 8'h00);
      timeout_det_en_i = 1'b1;
      pulse_timeout();
      cmp_bit(int_n, 1'b1);
      rd_chk(8'h48, 8'h01);
      rd_chk(8'h48, 8'h00);
      u_glc_host_model.write(8'h40, 8'h30);
      pulse_timeout();
      cmp_bit(int_n, 1'b0);
      wait_cyc(5);
      cmp_bit(int_n, 1'b0);
      rd_chk(8'h48, 8'h01);
      cmp_bit(int_n, 1'b1);
   endtask : t_timeout

   task automatic t_soft_reset();
      u_glc_host_model.write(8'h45, 8'h33);
      u_glc_host_model.write(8'h40, 8'h1D);
      cmp_bit(soft_rst, 1'b1);
      wait_cyc(1);
      cmp_bit(soft_rst, 1'b0);
      rd_chk(8'h40, 8'h00);
      rd_chk(8'h42, 8'h00);
      rd_chk(8'h43, 8'hC0);
      rd_chk(8'h45, 8'h00);
      cmp_bit(func_en, 1'b0);
      duty_chk(0, 9'h000);
   endtask : t_soft_reset

   always @(posedge sys_clk_i) begin
      cycles++;
      // ceiling well above the roughly 4700 cycles the sequence needs
      if (cycles == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      error_cnt = 0;
      checked = 0;
      cycles = 0;
      rst_n_i = 1'b0;
      bus_timeout_i = 1'b0;
      timeout_det_en_i = 1'b0;
      key_sleep_i = 1'b0;
      fade_up_i = 1'b1;
      sel = 4'h1;
      own = {8'h10, 8'h10, 8'h40, 8'h00};
      repeat (16) @(posedge sys_clk_i);
      #1;
      rst_n_i = 1'b1;
      t_reset_values();
      t_lock_sleep();
      t_enable();
      t_pwm();
      t_fade();
      t_timeout();
      t_soft_reset();
      test_done();
   end
endmodule : gpio_led_global_control_bench
